// *** imp_pkg.sv ***
// constants shared by the interrupt conditioning stage
package imp_pkg;
   // =====================================================
   // register bus geometry
   localparam int unsigned ADDR_W  = 8;
   localparam int unsigned DATA_W  = 16;
   localparam int unsigned SRC_N   = 10;

   // =====================================================
   // register offsets
   localparam logic [7:0] OFS_STATUS   = 8'h7f;
   localparam logic [7:0] OFS_MASK     = 8'h80;
   localparam logic [7:0] OFS_POLARITY = 8'h81;
   localparam logic [7:0] OFS_DEBOUNCE = 8'h82;

   // =====================================================
   // common bit layout of mask, polarity, debounce and status
   localparam int unsigned BIT_PIN4     = 9;
   localparam int unsigned BIT_SEQ      = 8;
   localparam int unsigned BIT_PIN3     = 7;
   localparam int unsigned BIT_PIN2     = 6;
   localparam int unsigned BIT_PIN1     = 5;
   localparam int unsigned BIT_INPUT8   = 4;
   localparam int unsigned BIT_INPUT7   = 3;
   localparam int unsigned BIT_LOCK     = 2;
   localparam int unsigned BIT_SHORT    = 1;
   localparam int unsigned BIT_DETECT   = 0;
   localparam int unsigned BIT_COMBINED = 10;

   // =====================================================
   // reset values
   localparam logic [9:0] RST_MASK     = 10'h3ff;
   localparam logic [9:0] RST_POLARITY = 10'h000;
   localparam logic [9:0] RST_DEBOUNCE = 10'h000;
   localparam logic [9:0] RST_FLAGS    = 10'h000;

   // =====================================================
   // debounce timing: slow sample period and stable sample count
   localparam int unsigned CLK_HZ          = 25_000_000;
   localparam int unsigned SAMPLE_PERIOD_US = 100;
   localparam int unsigned SAMPLE_CYCLES   = (CLK_HZ / 1_000_000) * SAMPLE_PERIOD_US;
   localparam int unsigned STABLE_SAMPLES  = 4;
   localparam int unsigned TICK_W          = 12;
   localparam int unsigned RUN_W           = 3;
endpackage

// *** imp_cond_if.sv ***
// carrier between the register file and the debounce filter
`timescale 1ns/1ps
interface imp_cond_if;
   logic [9:0] debounce_en;   // per source filter enable
   logic [9:0] cond;          // polarity adjusted conditions
   logic [9:0] filtered;      // conditions after optional filter
   modport ctrl (output debounce_en, output cond, input filtered);
   modport filt (input debounce_en, input cond, output filtered);
endinterface

// *** imp_debounce.sv ***
// per-source debounce filter on a slow sample tick
`timescale 1ns/1ps
module imp_debounce
   import imp_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   input  wire logic ce_i,
   imp_cond_if.filt  cif
);
   import imp_pkg::*;

   // =====================================================
   // slow sample tick
   logic [TICK_W-1:0] tick_cnt;            // cycles since last sample
   logic [9:0]        stable;              // last accepted level per source
   logic [RUN_W-1:0]  run [SRC_N];         // samples seen differing from stable
   wire               tick = (tick_cnt == TICK_W'(SAMPLE_CYCLES - 1));

   // free running divider, so all sources share one sample grid
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         tick_cnt <= '0;
      end else if (ce_i) begin
         tick_cnt <= tick ? '0 : tick_cnt + TICK_W'(1);
      end
   end

   // =====================================================
   // per source stability counters
   // a change passes only after STABLE_SAMPLES equal samples
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         stable <= '0;
         for (int i = 0; i < SRC_N; i++) begin
            run[i] <= '0;
         end
      end else if (ce_i && tick) begin
         for (int i = 0; i < SRC_N; i++) begin
            if (cif.cond[i] == stable[i]) begin
               run[i] <= '0;                // glitch ended, restart
            end else if (run[i] == RUN_W'(STABLE_SAMPLES - 1)) begin
               stable[i] <= cif.cond[i];
               run[i]    <= '0;
            end else begin
               run[i] <= run[i] + RUN_W'(1);
            end
         end
      end
   end

   // bypass when the enable is clear, filtered otherwise
   assign cif.filtered = (cif.debounce_en & stable) | (~cif.debounce_en & cif.cond);
endmodule

// *** imp_top.sv ***
// interrupt mask, polarity, debounce and flag logic for ten sources
// =====================================================
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module imp_top
   import imp_pkg::*;
(
   input  wire logic              clk_i,       // system clock, 25 MHz
   input  wire logic              sys_rst_i,   // synchronous reset, active high
   input  wire logic              ce_i,        // clock enable, freezes state when low
   input  wire logic [ADDR_W-1:0] addr_i,      // register address
   input  wire logic [DATA_W-1:0] wdata_i,     // write data
   input  wire logic              wr_i,        // write strobe
   input  wire logic              rd_i,        // read strobe
   output      logic [DATA_W-1:0] rdata_o,     // read data, cycle after strobe
   input  wire logic [3:0]        pin_i,       // pins one to four, asynchronous
   input  wire logic [1:0]        input_i,     // input pins seven, eight
   input  wire logic              seq_busy_i,  // write sequencer busy
   input  wire logic              lock_i,      // frequency locked loop locked
   input  wire logic              short_i,     // microphone bias short circuit
   input  wire logic              detect_i,    // microphone bias current detect
   output      logic              irq_o        // level interrupt, active high
);
   import imp_pkg::*;

   // =====================================================
   // registers
   logic [9:0] interrupt_mask;          // 1 suppresses a source
   logic [9:0] interrupt_polarity;      // 1 selects active low
   logic [9:0] interrupt_debounce;      // 1 enables the filter
   logic [9:0] flags;                   // sticky source flags
   logic [9:0] sync_a;                  // first synchroniser stage
   logic [9:0] sync_b;                  // second synchroniser stage
   logic [9:0] raw;                     // source levels in bit layout

   imp_cond_if cif ();

   // =====================================================
   // source gathering into the shared bit order
   // pins are assembled before synchronising so every bit gets two stages
   always_comb begin
      raw              = '0;
      raw[BIT_PIN4]    = pin_i[3];
      raw[BIT_SEQ]     = seq_busy_i;
      raw[BIT_PIN3]    = pin_i[2];
      raw[BIT_PIN2]    = pin_i[1];
      raw[BIT_PIN1]    = pin_i[0];
      raw[BIT_INPUT8]  = input_i[1];
      raw[BIT_INPUT7]  = input_i[0];
      raw[BIT_LOCK]    = lock_i;
      raw[BIT_SHORT]   = short_i;
      raw[BIT_DETECT]  = detect_i;
   end

   // two flop synchroniser; only sync_b is read by logic
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sync_a <= '0;
         sync_b <= '0;
      end else if (ce_i) begin
         sync_a <= raw;
         sync_b <= sync_a;
      end
   end

   // =====================================================
   // polarity and filter
   // xor flips active low sources so the filter and flags see "true" as one
   assign cif.cond        = sync_b ^ interrupt_polarity;
   assign cif.debounce_en = interrupt_debounce;

   imp_debounce u_debounce (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .ce_i      (ce_i),
      .cif       (cif)
   );

   // =====================================================
   // bus decode
   wire hit_status   = (addr_i == OFS_STATUS);
   wire hit_mask     = (addr_i == OFS_MASK);
   wire hit_polarity = (addr_i == OFS_POLARITY);
   wire hit_debounce = (addr_i == OFS_DEBOUNCE);
   wire wr_status    = wr_i && hit_status;
   wire [9:0] clear  = wr_status ? wdata_i[9:0] : 10'h000;

   // flags: level triggered, a set in the clear cycle wins
   wire [9:0] next_flags = (flags & ~clear) | cif.filtered;
   wire       combined   = |flags;
   wire [9:0] pending    = flags & ~interrupt_mask;

   // read mux, unmapped and reserved bits give zero
   logic [DATA_W-1:0] next_rdata;
   always_comb begin
      next_rdata = '0;
      if (hit_status) begin
         next_rdata[9:0]          = flags;
         next_rdata[BIT_COMBINED] = combined;
      end else if (hit_mask) begin
         next_rdata[9:0] = interrupt_mask;
      end else if (hit_polarity) begin
         next_rdata[9:0] = interrupt_polarity;
      end else if (hit_debounce) begin
         next_rdata[9:0] = interrupt_debounce;
      end
   end

   // =====================================================
   // configuration registers
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         interrupt_mask     <= RST_MASK;
         interrupt_polarity <= RST_POLARITY;
         interrupt_debounce <= RST_DEBOUNCE;
      end else if (ce_i && wr_i) begin
         if (hit_mask) begin
            interrupt_mask <= wdata_i[9:0];
         end
         if (hit_polarity) begin
            interrupt_polarity <= wdata_i[9:0];
         end
         if (hit_debounce) begin
            interrupt_debounce <= wdata_i[9:0];
         end
      end
   end

   // =====================================================
   // flags and read data
   // sequencer flag may toggle under busy reads; software must not trust it
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         flags   <= RST_FLAGS;
         rdata_o <= '0;
      end else if (ce_i) begin
         flags   <= next_flags;
         rdata_o <= rd_i ? next_rdata : '0;
      end
   end

   // interrupt output from registered flags and mask
   assign irq_o = |pending;
endmodule

// *** imp_chk.sv ***
// port assertions for the interrupt conditioning stage
`timescale 1ns/1ps
module imp_chk
   import imp_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              sys_rst_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   input  wire logic [DATA_W-1:0] rdata_o,
   input  wire logic              irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // =====================================================
   // bus cycles
   sequence s_wr(a);
      wr_i && addr_i == a;
   endsequence
   sequence s_rd(a);
      rd_i && addr_i == a;
   endsequence
   // quiet bus cycle between the two strobes, so nothing else can touch the register
   sequence s_idle;
      !wr_i && !rd_i;
   endsequence
   AST_MASK_RW: assert property (s_wr(OFS_MASK) ##1 s_idle ##1 s_rd(OFS_MASK) |=>
      rdata_o[9:0] == $past(wdata_i[9:0], 3)) else $error("mask readback wrong");
   AST_POL_RW: assert property (s_wr(OFS_POLARITY) ##1 s_idle ##1 s_rd(OFS_POLARITY) |=>
      rdata_o[9:0] == $past(wdata_i[9:0], 3)) else $error("polarity readback wrong");
   AST_DEB_RW: assert property (s_wr(OFS_DEBOUNCE) ##1 s_idle ##1 s_rd(OFS_DEBOUNCE) |=>
      rdata_o[9:0] == $past(wdata_i[9:0], 3)) else $error("debounce readback wrong");
   AST_RST_QUIET: assert property ($fell(sys_rst_i) |-> !irq_o && rdata_o == '0)
      else $error("outputs not quiet after reset");
   AST_IDLE_ZERO: assert property (!rd_i |=> rdata_o == '0)
      else $error("read data outside read cycle");
   AST_UNMAPPED: assert property (rd_i && (addr_i > OFS_DEBOUNCE || addr_i < OFS_STATUS) |=> rdata_o == '0)
      else $error("unmapped read not zero");
   AST_HIGH_ZERO: assert property (rd_i && addr_i != OFS_STATUS |=> rdata_o[15:10] == '0)
      else $error("upper bits not zero");
   AST_COMBINED: assert property (s_rd(OFS_STATUS) |=> rdata_o[10] == |rdata_o[9:0])
      else $error("combined bit wrong");
   AST_ALL_MASKED: assert property (s_rd(OFS_MASK) ##1 rdata_o[9:0] == 10'h3ff |-> !irq_o)
      else $error("irq while all masked");
endmodule
bind imp_top imp_chk i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));

// *** imp_src_model.sv ***
// model of the event sources, events given in register bit order
`timescale 1ns/1ps
module imp_src_model
   import imp_pkg::*;
(
   input  wire logic [9:0] ev_i,
   output      logic [3:0] pin_o,
   output      logic [1:0] input_o,
   output      logic       busy_o,
   output      logic       lock_o,
   output      logic       short_o,
   output      logic       detect_o
);
   // =====================================================
   // layout to pin mapping
   assign pin_o    = {ev_i[BIT_PIN4], ev_i[BIT_PIN3], ev_i[BIT_PIN2], ev_i[BIT_PIN1]};
   assign input_o  = {ev_i[BIT_INPUT8], ev_i[BIT_INPUT7]};
   assign busy_o   = ev_i[BIT_SEQ];
   assign lock_o   = ev_i[BIT_LOCK];
   assign short_o  = ev_i[BIT_SHORT];
   assign detect_o = ev_i[BIT_DETECT];
endmodule

// *** tb.sv ***
// self-checking bench for the conditioning stage
`timescale 1ns/1ps
module tb;
   import imp_pkg::*;
   logic              clk_i = 1'b0;
   logic              sys_rst_i = 1'b1;
   logic              wr_i = 1'b0;
   logic              rd_i = 1'b0;
   logic [ADDR_W-1:0] addr_i = '0;
   logic [DATA_W-1:0] wdata_i = '0;
   logic [DATA_W-1:0] rdata_o;
   logic [9:0]        ev = '0;
   logic [3:0]        pin;
   logic [1:0]        inp;
   logic [3:0]        misc;
   logic              irq_o;
   int                n_errors = 0;
   int                checked = 0;
   always #20 clk_i = ~clk_i;
   imp_src_model i_src (.ev_i(ev), .pin_o(pin), .input_o(inp), .busy_o(misc[3]),
      .lock_o(misc[2]), .short_o(misc[1]), .detect_o(misc[0]));
   imp_top i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin),
      .input_i(inp), .seq_busy_i(misc[3]), .lock_i(misc[2]), .short_i(misc[1]),
      .detect_i(misc[0]), .irq_o(irq_o));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, e);
   endtask
   task automatic complete_run;
      if (n_errors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // watchdog: the whole run is bounded
   initial begin
      #4_000_000;
      n_errors++;
      complete_run;
   end
   initial begin
      cyc(16);
      sys_rst_i <= 1'b0;
      rd(OFS_MASK, 16'h03ff);
      rd(OFS_POLARITY, 16'h0000);
      rd(OFS_DEBOUNCE, 16'h0000);
      rd(8'h83, 16'h0000);
      wr(OFS_MASK, 16'hfd55);
      rd(OFS_MASK, 16'h0155);
      wr(OFS_MASK, 16'h03ff);
      wr(OFS_DEBOUNCE, 16'hffa5);
      rd(OFS_DEBOUNCE, 16'h03a5);
      wr(OFS_DEBOUNCE, 16'h0000);
      // each source in turn: set, sticky, masked, unmasked, cleared
      for (int i = 0; i < SRC_N; i++) begin
         @(posedge clk_i);
         ev <= 10'h001 << i;
         cyc(4);
         ev <= '0;
         cyc(4);
         rd(OFS_STATUS, 16'h0400 | (16'h0001 << i));
         chk({15'h0, irq_o}, 16'h0000);
         wr(OFS_MASK, 16'h03ff ^ (16'h0001 << i));
         chk({15'h0, irq_o}, 16'h0001);
         wr(OFS_STATUS, 16'h0001 << i);
         chk({15'h0, irq_o}, 16'h0000);
         wr(OFS_MASK, 16'h03ff);
      end
      ev[BIT_LOCK] <= 1'b1;
      cyc(4);
      wr(OFS_STATUS, 16'h0004);
      rd(OFS_STATUS, 16'h0404);
      ev <= '0;
      cyc(4);
      wr(OFS_POLARITY, 16'h0104);
      rd(OFS_POLARITY, 16'h0104);
      cyc(4);
      rd(OFS_STATUS, 16'h0504);
      wr(OFS_POLARITY, 16'h0000);
      cyc(4);
      wr(OFS_STATUS, 16'h03ff);
      rd(OFS_STATUS, 16'h0000);
      // filtered pin one: short pulse dropped, long level passed
      wr(OFS_DEBOUNCE, 16'h0020);
      ev[BIT_PIN1] <= 1'b1;
      cyc(10);
      ev <= '0;
      cyc(2 * SAMPLE_CYCLES);
      rd(OFS_STATUS, 16'h0000);
      ev[BIT_PIN1] <= 1'b1;
      cyc(2 * SAMPLE_CYCLES);
      rd(OFS_STATUS, 16'h0000);
      cyc(4 * SAMPLE_CYCLES);
      rd(OFS_STATUS, 16'h0420);
      complete_run;
   end
endmodule
